// File: hdl/tx_rs_pkg.sv
/*
  Shared constants, types and the GF(256) multiply for the transmit
  RS encoder and bit mapper. Assumes nothing beyond a SystemVerilog tool.
*/
package tx_rs_pkg;
  // ==========================================================================
  // Register map (indices; byte address is four times the index)
  localparam logic [7:0] IDX_MODULATION_SELECT = 8'h2C;
  localparam logic [7:0] IDX_BIT_ORDER_MAP_SELECT = 8'h2D;
  localparam logic [7:0] IDX_CODEC_POLY_CAPABILITY = 8'h36;
  localparam logic [7:0] IDX_PAYLOAD_LENGTH = 8'h37;
  localparam logic [7:0] IDX_CODEC_BIT_ORDER = 8'h39;
  localparam logic [7:0] IDX_ENCODER_STATUS = 8'h3A;
  localparam int APB_ADDR_WIDTH = 12;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_MODULATION_SELECT = 8'h00;
  localparam logic [7:0] RST_BIT_ORDER_MAP_SELECT = 8'h00;
  localparam logic [7:0] RST_CODEC_POLY_CAPABILITY = 8'h41;
  localparam logic [7:0] RST_PAYLOAD_LENGTH = 8'h10;
  localparam logic [7:0] RST_CODEC_BIT_ORDER = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int POS_MOD_HI = 3;
  localparam int POS_MOD_LO = 2;
  localparam int POS_MAP_HI = 6;
  localparam int POS_MAP_LO = 4;
  localparam int POS_FIELD_POLYNOMIAL_SEL = 7;
  localparam int POS_ENCODER_ENABLE = 6;
  localparam int POS_SCRAMBLE_FIRST = 5;
  localparam int POS_T_HI = 3;
  localparam int POS_INPUT_LSB_FIRST = 4;
  localparam int POS_PARITY_LSB_FIRST = 5;
  localparam int POS_STAT_PARITY = 0;
  localparam int POS_STAT_GEN_BUSY = 1;

  // ==========================================================================
  // Code parameters
  localparam logic [3:0] T_MIN = 4'h1;
  localparam logic [3:0] T_MAX = 4'hA;
  localparam int NPAR = 20;
  localparam logic [7:0] ROOT_OFFSET_ALT = 8'h78;
  localparam logic [7:0] GF_ALPHA = 8'h02;
  localparam logic [7:0] GF_REDUCE_0 = 8'h1D;
  localparam logic [7:0] GF_REDUCE_1 = 8'h87;

  typedef enum logic [1:0]
  {
    GEN_IDLE = 2'b00,
    GEN_SKIP = 2'b01,
    GEN_BUILD = 2'b10
  } gen_state_type;

  typedef logic [NPAR-1:0][7:0] parity_array_type;

  // Multiply in GF(256); sel picks the field polynomial.
  function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b, input logic sel);
    logic [7:0] acc;
    logic [7:0] x;
    acc = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++)
    begin
      if (b[i])
        acc = acc ^ x;
      x = x[7] ? ({x[6:0], 1'b0} ^ (sel ? GF_REDUCE_1 : GF_REDUCE_0)) : {x[6:0], 1'b0};
    end
    return acc;
  endfunction
endpackage

// File: hdl/gen_poly_if.sv
/*
  Link between the encoder and its generator polynomial builder.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface gen_poly_if;
  import tx_rs_pkg::*;
  logic poly_sel;
  logic [3:0] t;
  logic start;
  logic busy;
  parity_array_type coeff;
  modport builder (input poly_sel, input t, input start, output busy, output coeff);
  modport user (output poly_sel, output t, output start, input busy, input coeff);
endinterface

// File: hdl/gen_poly_builder.sv
/*
  Builds the monic RS generator polynomial, one root per clock.
  Assumes t is already clamped to 1..10 and stays put while busy.
*/
`timescale 1ns/10ps
module gen_poly_builder
  import tx_rs_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic rstn, // Asynchronous reset, active low.
  gen_poly_if.builder gp // Configuration in, coefficients out.
);
  typedef struct packed
  {
    gen_state_type st;
    logic [7:0] root;
    logic [7:0] cnt;
    logic [NPAR:0][7:0] g;
  } builder_state_type;

  builder_state_type s;
  builder_state_type next_s;
  logic [4:0] twot;

  assign twot = {gp.t, 1'b0};
  assign gp.busy = (s.st != GEN_IDLE);
  assign gp.coeff = s.g[NPAR-1:0];

  // ==========================================================================
  // Root stepping and polynomial growth
  always_comb
  begin
    next_s = s;
    unique case (s.st)
      GEN_IDLE:
      begin
        if (gp.start)
        begin
          next_s.g = '0;
          next_s.g[0] = 8'h01;
          next_s.root = 8'h01;
          next_s.cnt = 8'h00;
          next_s.st = gp.poly_sel ? GEN_SKIP : GEN_BUILD;
        end
      end
      GEN_SKIP:
      begin
        // Roots start at alpha^120 for the alternate field.
        next_s.root = gf_mul(s.root, GF_ALPHA, gp.poly_sel);
        next_s.cnt = s.cnt + 8'h01;
        if (s.cnt == ROOT_OFFSET_ALT - 8'h01)
        begin
          next_s.cnt = 8'h00;
          next_s.st = GEN_BUILD;
        end
      end
      GEN_BUILD:
      begin
        for (int j = 0; j <= NPAR; j++)
          next_s.g[j] = (j > 0 ? s.g[j-1] : 8'h00) ^ gf_mul(s.g[j], s.root, gp.poly_sel);
        next_s.root = gf_mul(s.root, GF_ALPHA, gp.poly_sel);
        next_s.cnt = s.cnt + 8'h01;
        if (s.cnt == {3'b000, twot} - 8'h01)
          next_s.st = GEN_IDLE;
      end
      default:
        next_s.st = GEN_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      s <= '0;
    else
      s <= next_s;
  end
endmodule

// File: hdl/tx_rs_encoder_bit_mapper.sv
/*
  Transmit Reed-Solomon encoder followed by the serial-to-symbol bit mapper,
  with an APB3 register slave. Assumes the serial source runs on its own
  input clock, which is resynchronised here, well below CLK_SYS.
*/
// What this block does
// - RS encode over GF(256); correctable count T valid from 1 to 10.
// - Payload length K is 8 bits, 1 to 255-2T; block is K+2T.
// - With qualifier high and encoder on, input bits pass through and feed checksum.
// - After each K payload bytes, insert the 2T-byte checksum.
// - Input data is ignored while the checksum is being inserted.
// - Parity flag is high exactly during the 2T checksum bytes.
// - Polynomial select bit picks one of the two field polynomials.
// - T comes from the low nibble of the codec register.
// - Alternate field: generator roots alpha^120 up to alpha^(119+2T).
// - Default field: generator roots alpha^0 up to alpha^(2T-1).
// - Input order bit: first serial bit becomes byte MSB or LSB.
// - Parity order bit: checksum bytes sent MSB first or LSB first.
// - Mapper always outputs four symbol bits I1 I0 Q1 Q0.
// - BPSK copies each bit to all four symbol bits, order ignored.
// - QPSK pairs bits; order bit 0 picks I first or Q first.
// - 16QAM order 000..011 map nibbles in the four bytewise orders.
// - 16QAM order 100..111 map nibbles in the four interleaved orders.
// - The earliest arriving bit takes I1 in BPSK, in QPSK with order bit 0 clear, and in 16QAM with order bits 1:0 clear.
// - Data advances only when the qualifier is high at a bit clock fall.
// - Encoder enable bit low bypasses encoding; scramble order bit is stored.
`timescale 1ns/10ps
module tx_rs_encoder_bit_mapper
  import tx_rs_pkg::*;
(
  input wire logic CLK_SYS, // System clock, 20 MHz.
  input wire logic RSTN, // Asynchronous reset, active low.
  input wire logic PSEL, // APB select.
  input wire logic PENABLE, // APB access phase.
  input wire logic PWRITE, // APB direction, high for write.
  input wire logic [APB_ADDR_WIDTH-1:0] PADDR, // APB byte address.
  input wire logic [31:0] PWDATA, // APB write data.
  output logic [31:0] PRDATA, // APB read data.
  output logic PREADY, // APB ready.
  output logic PSLVERR, // APB error on unmapped address.
  input wire logic SERIAL_INPUT_CLOCK, // Source bit clock.
  input wire logic SERIAL_DATA_QUALIFIER, // Source data enable.
  input wire logic SERIAL_INPUT_STREAM, // Source serial data.
  output logic BIT_RATE_STROBE, // Bit clock returned to the source.
  output logic PARITY_INSERT_FLAG, // High while checksum bytes are sent.
  output logic CODED_BIT, // Encoded serial output bit.
  output logic CODED_STROBE, // One-cycle pulse marking CODED_BIT.
  output logic SYM_I1, // Symbol bit I1.
  output logic SYM_I0, // Symbol bit I0.
  output logic SYM_Q1, // Symbol bit Q1.
  output logic SYM_Q0, // Symbol bit Q0.
  output logic SYM_STROBE // One-cycle pulse marking a new symbol.
);
  typedef struct packed
  {
    logic [7:0] modulation_select;
    logic [7:0] bit_order_map_select;
    logic [7:0] codec_poly_capability;
    logic [7:0] payload_length;
    logic [7:0] codec_bit_order;
    logic [31:0] rdata;
    logic gen_pending;
    logic gen_start;
    logic [2:0] clk_sync;
    logic [1:0] qual_sync;
    logic [1:0] data_sync;
    logic in_parity;
    logic flag;
    logic [2:0] bit_cnt;
    logic [7:0] byte_cnt;
    logic [4:0] par_cnt;
    logic [7:0] shift_byte;
    parity_array_type par;
    logic coded_bit;
    logic coded_strobe;
    logic [3:0] sym_bits;
    logic [1:0] sym_cnt;
    logic [3:0] sym_out;
    logic sym_strobe;
  } top_state_type;

  top_state_type s;
  top_state_type next_s;
  logic [3:0] t_eff;
  logic [4:0] twot;
  logic poly_sel;
  logic advance;
  logic bit_in;
  logic apb_setup;
  logic apb_write;
  logic mapped;
  logic [7:0] widx;

  gen_poly_if gp ();

  gen_poly_builder u_builder
  (
    .clk(CLK_SYS),
    .rstn(RSTN),
    .gp(gp.builder)
  );

  // ==========================================================================
  // Configuration decode
  always_comb
  begin
    t_eff = s.codec_poly_capability[POS_T_HI:0];
    // Out-of-range T is clamped so the parity array can never overrun.
    if (t_eff < T_MIN)
      t_eff = T_MIN;
    else if (t_eff > T_MAX)
      t_eff = T_MAX;
  end

  assign twot = {t_eff, 1'b0};
  assign poly_sel = s.codec_poly_capability[POS_FIELD_POLYNOMIAL_SEL];
  assign gp.poly_sel = poly_sel;
  assign gp.t = t_eff;
  assign gp.start = s.gen_start;

  // ==========================================================================
  // APB decode
  assign widx = PADDR[9:2];
  assign apb_setup = PSEL && !PENABLE;
  assign apb_write = PSEL && PENABLE && PWRITE && mapped;
  assign mapped = (PADDR[1:0] == 2'b00) && (PADDR[APB_ADDR_WIDTH-1:10] == '0) &&
                  (widx == IDX_MODULATION_SELECT || widx == IDX_BIT_ORDER_MAP_SELECT ||
                   widx == IDX_CODEC_POLY_CAPABILITY || widx == IDX_PAYLOAD_LENGTH ||
                   widx == IDX_CODEC_BIT_ORDER || widx == IDX_ENCODER_STATUS);
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign PRDATA = s.rdata;

  // ==========================================================================
  // Link sampling: the bit clock fall is seen after two synchroniser flops.
  assign advance = s.clk_sync[2] && !s.clk_sync[1] && s.qual_sync[1];
  assign bit_in = s.data_sync[1];

  // ==========================================================================
  // Next state
  always_comb
  begin
    logic [7:0] full_byte;
    logic [7:0] fb;
    logic [7:0] top;
    logic [3:0] b;
    logic xa;
    logic xb;
    logic ya;
    logic yb;
    logic x1;
    logic x0;
    logic [2:0] ord;
    logic [1:0] need;
    full_byte = 8'h00;
    fb = 8'h00;
    top = 8'h00;
    b = 4'h0;
    xa = 1'b0;
    xb = 1'b0;
    ya = 1'b0;
    yb = 1'b0;
    x1 = 1'b0;
    x0 = 1'b0;
    ord = s.bit_order_map_select[POS_MAP_HI:POS_MAP_LO];
    need = 2'd0;
    next_s = s;
    next_s.gen_start = 1'b0;
    next_s.coded_strobe = 1'b0;
    next_s.sym_strobe = 1'b0;

    // Read data is caught in the setup phase so PRDATA is a flop.
    if (apb_setup)
    begin
      next_s.rdata = 32'h0000_0000;
      unique case (widx)
        IDX_MODULATION_SELECT: next_s.rdata[7:0] = s.modulation_select;
        IDX_BIT_ORDER_MAP_SELECT: next_s.rdata[7:0] = s.bit_order_map_select;
        IDX_CODEC_POLY_CAPABILITY: next_s.rdata[7:0] = s.codec_poly_capability;
        IDX_PAYLOAD_LENGTH: next_s.rdata[7:0] = s.payload_length;
        IDX_CODEC_BIT_ORDER: next_s.rdata[7:0] = s.codec_bit_order;
        IDX_ENCODER_STATUS:
        begin
          next_s.rdata[POS_STAT_PARITY] = s.in_parity;
          next_s.rdata[POS_STAT_GEN_BUSY] = gp.busy || s.gen_pending;
        end
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
    if (apb_write)
    begin
      unique case (widx)
        IDX_MODULATION_SELECT: next_s.modulation_select = PWDATA[7:0];
        IDX_BIT_ORDER_MAP_SELECT: next_s.bit_order_map_select = PWDATA[7:0];
        IDX_CODEC_POLY_CAPABILITY: next_s.codec_poly_capability = PWDATA[7:0];
        IDX_PAYLOAD_LENGTH: next_s.payload_length = PWDATA[7:0];
        IDX_CODEC_BIT_ORDER: next_s.codec_bit_order = PWDATA[7:0];
        default: next_s.rdata = s.rdata;
      endcase
    end

    // A new field or T forces a rebuild; a write in the start cycle is kept.
    if (s.gen_pending && !gp.busy && !s.gen_start)
    begin
      next_s.gen_start = 1'b1;
      next_s.gen_pending = 1'b0;
    end
    if (apb_write && widx == IDX_CODEC_POLY_CAPABILITY)
      next_s.gen_pending = 1'b1;

    next_s.clk_sync = {s.clk_sync[1:0], SERIAL_INPUT_CLOCK};
    next_s.qual_sync = {s.qual_sync[0], SERIAL_DATA_QUALIFIER};
    next_s.data_sync = {s.data_sync[0], SERIAL_INPUT_STREAM};

    // Encoder.
    next_s.flag = s.flag & s.in_parity;
    if (advance)
    begin
      next_s.coded_strobe = 1'b1;
      if (!s.codec_poly_capability[POS_ENCODER_ENABLE])
        next_s.coded_bit = bit_in;
      else if (!s.in_parity)
      begin
        next_s.coded_bit = bit_in;
        full_byte = s.codec_bit_order[POS_INPUT_LSB_FIRST] ? {bit_in, s.shift_byte[7:1]} :
                                                             {s.shift_byte[6:0], bit_in};
        next_s.shift_byte = full_byte;
        next_s.bit_cnt = s.bit_cnt + 3'd1;
        if (s.bit_cnt == 3'd7)
        begin
          fb = full_byte ^ s.par[twot-5'd1];
          for (int j = 0; j < NPAR; j++)
            next_s.par[j] = (j < twot) ?
                            ((j > 0 ? s.par[j-1] : 8'h00) ^ gf_mul(fb, gp.coeff[j], poly_sel)) : 8'h00;
          next_s.byte_cnt = s.byte_cnt + 8'h01;
          if (s.byte_cnt + 8'h01 >= s.payload_length)
          begin
            next_s.byte_cnt = 8'h00;
            next_s.par_cnt = 5'd0;
            next_s.in_parity = 1'b1;
          end
        end
      end
      else
      begin
        // Input bits are dropped here; the source may keep running.
        top = s.par[twot-5'd1];
        next_s.flag = 1'b1;
        next_s.coded_bit = s.codec_bit_order[POS_PARITY_LSB_FIRST] ? top[s.bit_cnt] : top[3'd7 - s.bit_cnt];
        next_s.bit_cnt = s.bit_cnt + 3'd1;
        if (s.bit_cnt == 3'd7)
        begin
          for (int j = 0; j < NPAR; j++)
            next_s.par[j] = (j > 0 && j < twot) ? s.par[j-1] : 8'h00;
          next_s.par_cnt = s.par_cnt + 5'd1;
          if (s.par_cnt == twot - 5'd1)
            next_s.in_parity = 1'b0;
        end
      end
    end

    // Bit mapper: b[0] is always the earliest bit of the symbol.
    if (s.coded_strobe)
    begin
      b = s.sym_bits;
      b[s.sym_cnt] = s.coded_bit;
      next_s.sym_bits = b;
      next_s.sym_cnt = s.sym_cnt + 2'd1;
      if (s.modulation_select[POS_MOD_HI])
        need = 2'd0;
      else if (s.modulation_select[POS_MOD_LO])
        need = 2'd3;
      else
        need = 2'd1;
      if (s.sym_cnt >= need)
      begin
        next_s.sym_cnt = 2'd0;
        next_s.sym_strobe = 1'b1;
        if (need == 2'd0)
          next_s.sym_out = {4{b[0]}};
        else if (need == 2'd1)
          next_s.sym_out = ord[0] ? {b[1], b[1], b[0], b[0]} : {b[0], b[0], b[1], b[1]};
        else
        begin
          xa = b[0];
          xb = ord[2] ? b[2] : b[1];
          ya = ord[2] ? b[1] : b[2];
          yb = b[3];
          x1 = ord[1] ? xb : xa;
          x0 = ord[1] ? xa : xb;
          // sym_out holds I1 I0 Q1 Q0; order bit 0 swaps the I and Q rails.
          next_s.sym_out = ord[0] ? {(ord[1] ? yb : ya), (ord[1] ? ya : yb), x1, x0} :
                                    {x1, x0, (ord[1] ? yb : ya), (ord[1] ? ya : yb)};
        end
      end
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
    begin
      s <= '0;
      s.modulation_select <= RST_MODULATION_SELECT;
      s.bit_order_map_select <= RST_BIT_ORDER_MAP_SELECT;
      s.codec_poly_capability <= RST_CODEC_POLY_CAPABILITY;
      s.payload_length <= RST_PAYLOAD_LENGTH;
      s.codec_bit_order <= RST_CODEC_BIT_ORDER;
      s.gen_pending <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign BIT_RATE_STROBE = s.clk_sync[2];
  assign PARITY_INSERT_FLAG = s.flag;
  assign CODED_BIT = s.coded_bit;
  assign CODED_STROBE = s.coded_strobe;
  assign SYM_I1 = s.sym_out[3];
  assign SYM_I0 = s.sym_out[2];
  assign SYM_Q1 = s.sym_out[1];
  assign SYM_Q0 = s.sym_out[0];
  assign SYM_STROBE = s.sym_strobe;
endmodule

// File: bench/tx_rs_encoder_bit_mapper_assertions.sv
/*
  Port-level checker for the transmit encoder and bit mapper.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/10ps
module tx_rs_checker
(
  input wire logic CLK_SYS, // Clock.
  input wire logic RSTN, // Reset.
  input wire logic PSEL, // Select.
  input wire logic PENABLE, // Access phase.
  input wire logic PREADY, // Ready.
  input wire logic PSLVERR, // Error.
  input wire logic SERIAL_INPUT_CLOCK, // Source clock.
  input wire logic SERIAL_DATA_QUALIFIER, // Data enable.
  input wire logic BIT_RATE_STROBE, // Returned clock.
  input wire logic PARITY_INSERT_FLAG, // Parity flag.
  input wire logic CODED_STROBE, // Bit strobe.
  input wire logic SYM_I1, // Symbol bit.
  input wire logic SYM_I0, // Symbol bit.
  input wire logic SYM_Q1, // Symbol bit.
  input wire logic SYM_Q0, // Symbol bit.
  input wire logic SYM_STROBE // Symbol strobe.
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  // ==========================================================================
  // Parity strobes counted while the flag stands; at most 160.
  logic [7:0] par_cnt;
  logic [7:0] next_par_cnt;
  always_comb
  begin
    next_par_cnt = PARITY_INSERT_FLAG ? par_cnt + 8'(CODED_STROBE) : 8'h00;
  end
  always_ff @(posedge CLK_SYS or negedge RSTN)
  begin
    if (!RSTN)
      par_cnt <= 8'h00;
    else
      par_cnt <= next_par_cnt;
  end

  // ==========================================================================
  // A bit strobe must follow an enabled fall of the source clock.
  sequence src_fell;
    !$past(SERIAL_INPUT_CLOCK, 2) && $past(SERIAL_INPUT_CLOCK, 7) && $past(SERIAL_DATA_QUALIFIER, 4);
  endsequence

  strobe_cause_a: assert property (CODED_STROBE |-> src_fell)
    else $error("coded strobe without enabled source clock fall");
  strobe_space_a: assert property (CODED_STROBE |=> !CODED_STROBE [*6])
    else $error("coded strobes closer than one source period");
  bitclk_delay_a: assert property ($past(RSTN, 1) && $past(RSTN, 2) && $past(RSTN, 3)
    |-> BIT_RATE_STROBE == $past(SERIAL_INPUT_CLOCK, 3)) else $error("bit clock not three cycles late");
  flag_rise_a: assert property ($rose(PARITY_INSERT_FLAG) |-> CODED_STROBE)
    else $error("parity flag rose without a bit");
  flag_span_a: assert property (par_cnt <= 8'd160)
    else $error("parity flag stands too long");
  sym_follow_a: assert property (SYM_STROBE |-> $past(CODED_STROBE))
    else $error("symbol strobe not after a bit strobe");
  sym_hold_a: assert property (!SYM_STROBE |-> $stable({SYM_I1, SYM_I0, SYM_Q1, SYM_Q0}))
    else $error("symbol bits changed without strobe");
  apb_ready_a: assert property (PSEL && PENABLE |-> PREADY)
    else $error("register access not ready");
  apb_err_a: assert property (PSLVERR |-> PSEL && PENABLE)
    else $error("error outside access phase");
endmodule

// File: bench/serial_source_model.sv
/*
  Behavioural serial data source for the transmit encoder.
  Assumes the bench fills bit_q before calling run.
*/
`timescale 1ns/10ps
module serial_source_model
(
  output logic src_clk, // Source bit clock, still between frames.
  output logic src_qual, // Data enable.
  output logic src_data // Serial data.
);
  logic bit_q[$];
  initial
  begin
    src_clk = 1'b0;
    src_qual = 1'b0;
    src_data = 1'b1;
  end
  // Once bit_q runs dry the source keeps clocking random data, which the
  // device must ignore while it inserts parity.
  task automatic run(input int n);
    #13;
    for (int i = 0; i < n; i++)
    begin
      src_data = bit_q.size() ? bit_q.pop_front() : 1'($urandom);
      src_qual = 1'b1;
      src_clk = 1'b1;
      #200;
      src_clk = 1'b0;
      #200;
    end
    src_qual = 1'b0;
    src_data = ~src_data;
  endtask
endmodule

// File: bench/test_tx_rs_encoder_bit_mapper.sv
/*
  Self-checking bench for the transmit encoder and bit mapper.
  Assumes the checker and the serial source model are compiled first.
*/
`timescale 1ns/10ps
module test_tx_rs_encoder_bit_mapper
  import tx_rs_pkg::*;
;
  localparam logic [7:0] QAM_MAP [8] = '{8'hE4, 8'h4E, 8'hB1, 8'h1B, 8'hD8, 8'h72, 8'h8D, 8'h27};
  localparam logic [7:0] REG_IDX [5] = '{IDX_MODULATION_SELECT, IDX_BIT_ORDER_MAP_SELECT,
    IDX_CODEC_POLY_CAPABILITY, IDX_PAYLOAD_LENGTH, IDX_CODEC_BIT_ORDER};
  localparam logic [7:0] REG_RST [5] = '{RST_MODULATION_SELECT, RST_BIT_ORDER_MAP_SELECT,
    RST_CODEC_POLY_CAPABILITY, RST_PAYLOAD_LENGTH, RST_CODEC_BIT_ORDER};
  logic CLK_SYS = 1'b0;
  logic RSTN = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [APB_ADDR_WIDTH-1:0] PADDR = '0;
  logic [31:0] PWDATA = '0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, SERIAL_INPUT_CLOCK, SERIAL_DATA_QUALIFIER, SERIAL_INPUT_STREAM;
  logic BIT_RATE_STROBE, PARITY_INSERT_FLAG, CODED_BIT, CODED_STROBE;
  logic SYM_I1, SYM_I0, SYM_Q1, SYM_Q0, SYM_STROBE;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  logic cq[$];
  logic fq[$];
  logic [3:0] sq[$];

  always #25 CLK_SYS = ~CLK_SYS;

  tx_rs_encoder_bit_mapper dut (.CLK_SYS, .RSTN, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .SERIAL_INPUT_CLOCK, .SERIAL_DATA_QUALIFIER, .SERIAL_INPUT_STREAM,
    .BIT_RATE_STROBE, .PARITY_INSERT_FLAG, .CODED_BIT, .CODED_STROBE,
    .SYM_I1, .SYM_I0, .SYM_Q1, .SYM_Q0, .SYM_STROBE);
  serial_source_model src (.src_clk(SERIAL_INPUT_CLOCK), .src_qual(SERIAL_DATA_QUALIFIER),
    .src_data(SERIAL_INPUT_STREAM));

  // ==========================================================================
  // Output capture and hang limit.
  always @(posedge CLK_SYS)
  begin
    if (CODED_STROBE === 1'b1)
    begin
      cq.push_back(CODED_BIT);
      fq.push_back(PARITY_INSERT_FLAG);
    end
    if (SYM_STROBE === 1'b1)
      sq.push_back({SYM_I1, SYM_I0, SYM_Q1, SYM_Q0});
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rd,
    output logic err);
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= {2'b00, idx, 2'b00};
    PWDATA <= {24'h000000, wd};
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    @(posedge CLK_SYS);
    while (PREADY !== 1'b1)
      @(posedge CLK_SYS);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    logic [31:0] r;
    logic e;
    apb(1'b1, idx, v, r, e);
  endtask

  task automatic run_src(input int n);
    cq.delete();
    fq.delete();
    sq.delete();
    src.run(n);
    repeat (8) @(posedge CLK_SYS);
  endtask

  // ==========================================================================
  // Reference arithmetic over GF(256).
  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b, input logic pp);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      if (b[i])
        r = r ^ a;
      a = {a[6:0], 1'b0} ^ (a[7] ? (pp ? GF_REDUCE_1 : GF_REDUCE_0) : 8'h00);
    end
    return r;
  endfunction

  function automatic parity_array_type parity(input logic [7:0] d[$], input int t, input logic pp);
    logic [7:0] g [21];
    parity_array_type p;
    logic [7:0] r;
    logic [7:0] fb;
    g = '{default: 8'h00};
    g[0] = 8'h01;
    r = 8'h01;
    p = '0;
    for (int i = 0; i < (pp ? 120 : 0); i++)
      r = gmul(r, GF_ALPHA, pp);
    for (int j = 0; j < 2 * t; j++)
    begin
      for (int i = j + 1; i > 0; i--)
        g[i] = g[i - 1] ^ gmul(g[i], r, pp);
      g[0] = gmul(g[0], r, pp);
      r = gmul(r, GF_ALPHA, pp);
    end
    foreach (d[k])
    begin
      fb = d[k] ^ p[2 * t - 1];
      for (int i = 2 * t - 1; i > 0; i--)
        p[i] = p[i - 1] ^ gmul(g[i], fb, pp);
      p[0] = gmul(g[0], fb, pp);
    end
    return p;
  endfunction

  function automatic logic [3:0] exp_sym(input logic [1:0] md, input logic [2:0] ord, input logic [7:0] b,
    input int i);
    logic [3:0] s;
    s = 4'h0;
    if (md[1])
      s = {4{b[7 - i]}};
    else if (!md[0])
      s = ord[0] ? {{2{b[6 - 2 * i]}}, {2{b[7 - 2 * i]}}} : {{2{b[7 - 2 * i]}}, {2{b[6 - 2 * i]}}};
    else
      for (int j = 0; j < 4; j++)
        s[QAM_MAP[ord][7 - 2 * j -: 2]] = b[7 - 4 * i - j];
    return s;
  endfunction

  // ==========================================================================
  // Tests.
  task automatic reg_test();
    logic [31:0] r;
    logic e;
    logic [7:0] v;
    for (int i = 0; i < 5; i++)
    begin
      v = 8'($urandom);
      apb(1'b0, REG_IDX[i], 8'h00, r, e);
      check("reset value", {24'h0, REG_RST[i]}, r);
      wr(REG_IDX[i], v);
      apb(1'b0, REG_IDX[i], 8'h00, r, e);
      check("readback", {24'h0, v}, r);
    end
    apb(1'b0, 8'h3B, 8'h00, r, e);
    check("unmapped error", 1, e);
    $display("Register test done");
  endtask

  task automatic enc_test(input logic pp, input int t, input int k, input logic lin, input logic lpar);
    logic [7:0] d[$];
    logic e[$];
    parity_array_type p;
    logic [7:0] b;
    wr(IDX_CODEC_POLY_CAPABILITY, {pp, 3'b100, 4'(t)});
    wr(IDX_PAYLOAD_LENGTH, 8'(k));
    wr(IDX_CODEC_BIT_ORDER, {2'b00, lpar, lin, 4'h0});
    repeat (200) @(posedge CLK_SYS);
    for (int i = 0; i < k; i++)
    begin
      b = 8'($urandom);
      d.push_back(b);
      for (int j = 0; j < 8; j++)
        e.push_back(lin ? b[j] : b[7 - j]);
    end
    p = parity(d, t, pp);
    for (int i = 2 * t - 1; i >= 0; i--)
      for (int j = 0; j < 8; j++)
        e.push_back(lpar ? p[i][j] : p[i][7 - j]);
    src.bit_q = e[0:8 * k - 1];
    run_src(8 * (k + 2 * t));
    check("coded length", e.size(), cq.size());
    foreach (e[i])
    begin
      check("coded bit", e[i], cq[i]);
      check("parity flag", i >= 8 * k, fq[i]);
    end
    check("flag after block", 0, PARITY_INSERT_FLAG);
    $display("Encoder test done, T=%0d K=%0d", t, k);
  endtask

  task automatic map_test(input logic [1:0] md, input logic [2:0] ord);
    logic [7:0] b;
    int n;
    b = 8'($urandom);
    n = md[1] ? 8 : (md[0] ? 2 : 4);
    wr(IDX_MODULATION_SELECT, {4'h0, md, 2'b00});
    wr(IDX_BIT_ORDER_MAP_SELECT, {1'b0, ord, 4'h0});
    for (int i = 0; i < 8; i++)
      src.bit_q.push_back(b[7 - i]);
    run_src(8);
    check("symbol count", n, sq.size());
    for (int i = 0; i < n; i++)
      check("symbol", exp_sym(md, ord, b, i), sq[i]);
    for (int i = 0; i < 8; i++)
      check("bypass bit", b[7 - i], cq[i]);
    $display("Mapper test done, mode %b order %b", md, ord);
  endtask

  initial
  begin
    void'($urandom(32'h2EE5));
    repeat (20) @(posedge CLK_SYS);
    RSTN <= 1'b1;
    repeat (200) @(posedge CLK_SYS);
    check("flag after reset", 0, PARITY_INSERT_FLAG);
    reg_test();
    enc_test(1'b0, 1, 3, 1'b0, 1'b0);
    enc_test(1'b1, 2, 2, 1'b1, 1'b1);
    enc_test(1'b1, 10, 1, 1'b0, 1'b1);
    wr(IDX_CODEC_POLY_CAPABILITY, 8'h01);
    map_test(2'b10, 3'b101);
    map_test(2'b11, 3'b010);
    map_test(2'b00, 3'b110);
    map_test(2'b00, 3'b001);
    for (int o = 0; o < 8; o++)
      map_test(2'b01, 3'(o));
    wrap_up();
  end
endmodule

bind tx_rs_encoder_bit_mapper tx_rs_checker chk (.CLK_SYS, .RSTN, .PSEL, .PENABLE, .PREADY, .PSLVERR,
  .SERIAL_INPUT_CLOCK, .SERIAL_DATA_QUALIFIER, .BIT_RATE_STROBE, .PARITY_INSERT_FLAG, .CODED_STROBE,
  .SYM_I1, .SYM_I0, .SYM_Q1, .SYM_Q0, .SYM_STROBE);
